// file: adcb_correct.sv
// Offset and gain correction with saturation
`timescale 1ns/10ps
`default_nettype none
module adcb_correct
(
    input wire logic [15:0] i_raw,
    input wire logic [15:0] i_offset,
    input wire logic [15:0] i_gain,
    output logic [15:0] o_result,
    output logic o_sat
);
    logic signed [16:0] sum;
    logic signed [34:0] prod;
    logic signed [19:0] scaled;
    logic over;
    logic under;

    // ==========================
    // Arithmetic
    // ==========================
    // RULE1 add offset
    // One extra bit keeps the sum exact before gain
    assign sum = 17'($signed(i_raw)) + 17'($signed(i_offset));
    // RULE3 unsigned gain
    // Gain is 1.15 fixed point, zero-extended so it never reads negative
    assign prod = 35'(sum) * $signed({19'h00000, i_gain});
    assign scaled = prod[34:15];
    // RULE2 clamp and flag
    assign over = (scaled > 20'sh07FFF);
    assign under = (scaled < -20'sh08000);
    assign o_sat = over | under;
    assign o_result = over ? 16'h7FFF : (under ? 16'h8000 : scaled[15:0]);
endmodule
`default_nettype wire

// file: adcb_monitor.sv
// Checker: bus, transfer and selection properties at the converter back end ports
`timescale 1ns/10ps
`default_nettype none
module adcb_monitor
    import adcb_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic I_MOD_DONE,
    input wire logic [5:0] I_PIN_ANALOG,
    input wire logic [10:0] O_POS_SEL,
    input wire logic [10:0] O_NEG_SEL,
    input wire logic [2:0] O_PERIOD,
    input wire logic O_MOD_ENABLE,
    input wire logic [5:0] O_PIN_DIGITAL_OFF,
    input wire logic O_RAM_WRITE,
    input wire logic [15:0] O_RAM_ADDRESS
);
    // ==========================
    // Clocking and decode
    // ==========================
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);

    // Configuration write taking effect
    wire logic cfg_wr;
    assign cfg_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST && (I_AVS_ADDRESS == ADCB_OFFS_CONFIG);

    // ==========================
    // Assertions
    // ==========================
    chk_wait_one: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("bus answer held longer than one cycle");
    chk_answer_time: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
        && $past(O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST)
        else $error("bus answer late");
    chk_rdata_zero: assert property (O_AVS_WAITREQUEST |-> O_AVS_READDATA == 32'h0)
        else $error("read data outside answer cycle");
    chk_ram_pulse: assert property (O_RAM_WRITE |=> !O_RAM_WRITE)
        else $error("sample write longer than one cycle");
    chk_ram_cause: assert property (O_RAM_WRITE |-> $past(I_MOD_DONE, 3))
        else $error("sample write without conversion");
    chk_ram_even: assert property (O_RAM_WRITE |-> !O_RAM_ADDRESS[0])
        else $error("sample write to odd address");
    chk_pin_follow: assert property ($stable(I_PIN_ANALOG) [*4] |-> O_PIN_DIGITAL_OFF == I_PIN_ANALOG)
        else $error("pin digital disable does not follow");
    chk_sel_onehot: assert property ($onehot(O_POS_SEL) && $onehot(O_NEG_SEL))
        else $error("source select not one-hot");
    chk_sel_config: assert property (cfg_wr && I_AVS_WRITEDATA[11:8] == 4'h9
        |-> ##[1:2] O_POS_SEL == 11'h080)
        else $error("half reference not selected");
    // Enable and period reach the modulator one cycle after the answer
    chk_cfg_fields: assert property (cfg_wr |=> O_MOD_ENABLE == $past(I_AVS_WRITEDATA[0])
        && O_PERIOD == $past(I_AVS_WRITEDATA[3:1]))
        else $error("enable or period not applied");

    // Main scenarios reached
    cover property (O_RAM_WRITE);
    cover property (cfg_wr && I_AVS_WRITEDATA[0]);
    cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
endmodule

bind adcb_top adcb_monitor u_mon (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
    .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_MOD_DONE(I_MOD_DONE), .I_PIN_ANALOG(I_PIN_ANALOG),
    .O_POS_SEL(O_POS_SEL), .O_NEG_SEL(O_NEG_SEL), .O_PERIOD(O_PERIOD),
    .O_MOD_ENABLE(O_MOD_ENABLE), .O_PIN_DIGITAL_OFF(O_PIN_DIGITAL_OFF),
    .O_RAM_WRITE(O_RAM_WRITE), .O_RAM_ADDRESS(O_RAM_ADDRESS));
`default_nettype wire

// file: adcb_mux_decode.sv
// Input select decoder: one 4-bit code to a one-hot source enable
`timescale 1ns/10ps
`default_nettype none
module adcb_mux_decode
(
    input wire logic [3:0] i_code,
    output logic [10:0] o_sel
);
    // ==========================
    // Decode
    // ==========================
    // RULE15 code map
    // Bits 0..5 external inputs, 6 ground, 7 half ref, 8 full ref, 9 half regulator;
    // bit 10 flags an unconnected code so nothing is switched on
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_ext
            assign o_sel[g] = (i_code == 4'(g));
        end
    endgenerate
    assign o_sel[6] = (i_code == 4'h8);
    assign o_sel[7] = (i_code == 4'h9);
    assign o_sel[8] = (i_code == 4'hA);
    assign o_sel[9] = (i_code == 4'hB);
    assign o_sel[10] = ~|o_sel[9:0];
endmodule
`default_nettype wire

// file: adcb_partner.sv
// Partner model: modulator result source and RAM that records sample writes
`timescale 1ns/10ps
`default_nettype none
module adcb_partner
(
    input wire logic i_clk,
    output logic [15:0] o_mod_data,
    output logic o_mod_done,
    input wire logic i_ram_write,
    input wire logic [15:0] i_ram_address,
    input wire logic [15:0] i_ram_writedata
);
    logic [15:0] mem [0:255];
    logic [31:0] n_writes;
    logic [31:0] last_addr;

    initial
    begin
        o_mod_data = 16'h0000;
        o_mod_done = 1'b0;
        n_writes = 32'h0;
        last_addr = 32'h0;
    end

    // One conversion: data settles 3 cycles before done, done held 3 cycles
    task automatic convert(input logic [15:0] v);
        @(posedge i_clk);
        o_mod_data <= v;
        repeat (3) @(posedge i_clk);
        o_mod_done <= 1'b1;
        repeat (3) @(posedge i_clk);
        o_mod_done <= 1'b0;
        @(posedge i_clk);
        o_mod_data <= ~v; // Stale data never looks valid
        repeat (6) @(posedge i_clk);
    endtask

    // RAM store; half-word index from the byte address
    always @(posedge i_clk)
    begin
        if (i_ram_write)
        begin
            mem[i_ram_address[8:1]] <= i_ram_writedata;
            n_writes <= n_writes + 32'h1;
            last_addr <= {16'h0, i_ram_address};
        end
    end
endmodule
`default_nettype wire

// file: adcb_pkg.sv
// Package: register map, field layout, reset values and timing of the converter back end
package adcb_pkg;

    // ==========================
    // Register byte offsets
    // ==========================
    localparam logic [7:0] ADCB_OFFS_OFFSET = 8'h00;
    localparam logic [7:0] ADCB_OFFS_GAIN = 8'h04;
    localparam logic [7:0] ADCB_OFFS_CONFIG = 8'h08;
    localparam logic [7:0] ADCB_OFFS_BUF_START = 8'h0C;
    localparam logic [7:0] ADCB_OFFS_BUF_LEN = 8'h10;
    localparam logic [7:0] ADCB_OFFS_XFER_CTRL = 8'h14;
    localparam logic [7:0] ADCB_OFFS_CUR_PTR = 8'h18;
    localparam logic [7:0] ADCB_OFFS_FLAGS = 8'h1C;
    localparam logic [7:0] ADCB_OFFS_LAST = 8'h20;

    // ==========================
    // Reset values
    // ==========================
    localparam logic [15:0] ADCB_RST_OFFSET = 16'h0000;
    localparam logic [15:0] ADCB_RST_GAIN = 16'h8000;

    // ==========================
    // Configuration field positions
    // ==========================
    localparam int ADCB_CFG_EN = 0;
    localparam int ADCB_CFG_PERIOD_LO = 1;
    localparam int ADCB_CFG_MUXN_LO = 4;
    localparam int ADCB_CFG_MUXP_LO = 8;
    localparam int ADCB_CFG_WIDTH = 12;

    // Transfer control bits
    localparam int ADCB_XC_RESET = 0;
    localparam int ADCB_XC_LOAD = 1;
    localparam int ADCB_XC_WRAP = 2;

    // Flag bits
    localparam int ADCB_FL_SAT = 0;
    localparam int ADCB_FL_HALF = 1;
    localparam int ADCB_FL_FULL = 2;
    localparam int ADCB_FL_OVR = 3;

    // ==========================
    // Timing
    // ==========================
    localparam int ADCB_CLK_HZ = 20000000;
    localparam int ADCB_STARTUP_NS = 21000;
    localparam int ADCB_STARTUP_CYC = (ADCB_STARTUP_NS * (ADCB_CLK_HZ / 1000000) + 999) / 1000;
    // Sampling clocks for period code 0; doubles per code step
    localparam int ADCB_BASE_CLOCKS = 32;

    // Transfer channel states
    typedef enum logic [1:0] {ADCB_XS_IDLE, ADCB_XS_RUN, ADCB_XS_DONE} adcb_xstate_t;

endpackage

// file: adcb_top.sv
// Converter back end: registers, conversion sequencing, correction and sample transfer
// Function
// RULE1: Add offset to each raw result
// RULE2: Scale by gain, clamp, flag saturation
// RULE3: Gain is unsigned 1.15 fixed point
// RULE4: Reset offset zero, gain unity
// RULE5: Transfer corrected sample as 16-bit word
// RULE6: Software programs even start address
// RULE7: Length counts 16-bit samples
// RULE8: Reset channel, then load starts it
// RULE9: Wrap bit picks linear or wrap
// RULE10: Linear stops at count, sets full
// RULE11: Late conversion in linear sets overrun
// RULE12: Wrap returns pointer to start
// RULE13: Half and full flags per half
// RULE14: Current write pointer is readable
// RULE15: Decode input select codes
// RULE16: Software uses half reference single-ended
// RULE17: Analog pins read one, digital off
// RULE18: Software configures before configuration write
// RULE19: Continuous conversions, startup delay after off
// RULE20: Discard first conversion after changes
// RULE21: Period selects clocks, left-aligned result
// RULE22: Config rewrite leaves transfer running; here a rewrite that clears enable in wrap mode returns the channel to idle
// RULE23: Flags clear only on write one
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module adcb_top
    import adcb_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    // Avalon-MM slave
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Modulator side
    input wire logic [15:0] I_MOD_DATA,
    input wire logic I_MOD_DONE,
    input wire logic I_CLK_SWITCH,
    input wire logic [5:0] I_PIN_ANALOG,
    output logic [10:0] O_POS_SEL,
    output logic [10:0] O_NEG_SEL,
    output logic [2:0] O_PERIOD,
    output logic O_MOD_ENABLE,
    output logic [5:0] O_PIN_DIGITAL_OFF,
    // RAM write port
    output logic O_RAM_WRITE,
    output logic [15:0] O_RAM_ADDRESS,
    output logic [15:0] O_RAM_WRITEDATA
);
    // ==========================
    // Declarations
    // ==========================
    logic [15:0] offset_correction;
    logic [15:0] gain_correction;
    logic [ADCB_CFG_WIDTH-1:0] config_reg;
    logic [15:0] buffer_start_address;
    logic [15:0] buffer_length;
    logic wrap_mode_bit;
    logic [3:0] converter_event_flags;
    logic [15:0] current_write_pointer;
    logic [15:0] sample_index;
    adcb_xstate_t xstate;
    logic [15:0] raw_sync1;
    logic [15:0] raw_sync2;
    logic [2:0] done_sync;
    logic [1:0] clk_sw_sync;
    logic [5:0] pin_sync1;
    logic [5:0] pin_sync2;
    logic [12:0] startup_cnt;
    logic discard_next;
    logic was_enabled;
    logic ack;
    logic ack_q;
    logic [31:0] read_mux;
    logic [15:0] corrected;
    logic sat_now;
    logic [10:0] pos_sel;
    logic [10:0] neg_sel;
    logic conv_done;
    logic conv_accept;
    logic enabled;
    logic wr_offset;
    logic wr_gain;
    logic wr_config;
    logic wr_start;
    logic wr_len;
    logic wr_xctrl;
    logic wr_flags;
    logic xfer_reset;
    logic xfer_load;
    logic store;
    logic last_sample;
    logic half_point;
    logic [3:0] flag_set;
    logic [31:0] wd;
    logic [15:0] next_index;
    logic [15:0] next_pointer;

    // ==========================
    // Register decode
    // ==========================
    // Each access answers one cycle after it is presented
    assign ack = (I_AVS_READ | I_AVS_WRITE) & O_AVS_WAITREQUEST & ~ack_q;
    assign wd = I_AVS_WRITEDATA;
    assign wr_offset = ack & I_AVS_WRITE & (I_AVS_ADDRESS == ADCB_OFFS_OFFSET);
    assign wr_gain = ack & I_AVS_WRITE & (I_AVS_ADDRESS == ADCB_OFFS_GAIN);
    assign wr_config = ack & I_AVS_WRITE & (I_AVS_ADDRESS == ADCB_OFFS_CONFIG);
    assign wr_start = ack & I_AVS_WRITE & (I_AVS_ADDRESS == ADCB_OFFS_BUF_START);
    assign wr_len = ack & I_AVS_WRITE & (I_AVS_ADDRESS == ADCB_OFFS_BUF_LEN);
    assign wr_xctrl = ack & I_AVS_WRITE & (I_AVS_ADDRESS == ADCB_OFFS_XFER_CTRL);
    assign wr_flags = ack & I_AVS_WRITE & (I_AVS_ADDRESS == ADCB_OFFS_FLAGS);
    // RULE8 reset then load
    assign xfer_reset = wr_xctrl & wd[ADCB_XC_RESET];
    assign xfer_load = wr_xctrl & wd[ADCB_XC_LOAD] & ~wd[ADCB_XC_RESET];

    // Read data selection; unmapped offsets read zero
    always_comb
    begin
        unique case (I_AVS_ADDRESS)
            ADCB_OFFS_OFFSET: read_mux = {16'h0000, offset_correction};
            ADCB_OFFS_GAIN: read_mux = {16'h0000, gain_correction};
            ADCB_OFFS_CONFIG: read_mux = {20'h00000, config_reg};
            ADCB_OFFS_BUF_START: read_mux = {16'h0000, buffer_start_address};
            ADCB_OFFS_BUF_LEN: read_mux = {16'h0000, buffer_length};
            ADCB_OFFS_XFER_CTRL: read_mux = {29'h00000000, wrap_mode_bit, (xstate == ADCB_XS_RUN), 1'b0};
            ADCB_OFFS_CUR_PTR: read_mux = {16'h0000, current_write_pointer};
            ADCB_OFFS_FLAGS: read_mux = {28'h0000000, converter_event_flags};
            default: read_mux = 32'h00000000;
        endcase
    end

    // Bus handshake: waitrequest drops for exactly the answering cycle
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_N)
        begin
            ack_q <= 1'b0;
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h00000000;
        end
        else
        begin
            ack_q <= ack;
            O_AVS_WAITREQUEST <= ~ack;
            O_AVS_READDATA <= ack ? read_mux : 32'h00000000;
        end
    end

    // ==========================
    // Software registers
    // ==========================
    // RULE4 reset values
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_N)
        begin
            offset_correction <= ADCB_RST_OFFSET;
            gain_correction <= ADCB_RST_GAIN;
            config_reg <= '0;
            buffer_start_address <= 16'h0000;
            buffer_length <= 16'h0000;
            wrap_mode_bit <= 1'b0;
        end
        else
        begin
            if (wr_offset)
                offset_correction <= wd[15:0];
            if (wr_gain)
                gain_correction <= wd[15:0];
            if (wr_config)
                config_reg <= wd[ADCB_CFG_WIDTH-1:0];
            // Bit 0 ignored so samples stay half-word aligned
            if (wr_start)
                buffer_start_address <= {wd[15:1], 1'b0};
            if (wr_len)
                buffer_length <= wd[15:0];
            // RULE9 mode select
            if (xfer_load)
                wrap_mode_bit <= wd[ADCB_XC_WRAP];
        end
    end

    // ==========================
    // Input synchronisers
    // ==========================
    // Modulator data and strobe come from the analog side clock
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_N)
        begin
            raw_sync1 <= 16'h0000;
            raw_sync2 <= 16'h0000;
            done_sync <= 3'h0;
            clk_sw_sync <= 2'h0;
            pin_sync1 <= 6'h00;
            pin_sync2 <= 6'h00;
        end
        else
        begin
            raw_sync1 <= I_MOD_DATA;
            raw_sync2 <= raw_sync1;
            done_sync <= {done_sync[1:0], I_MOD_DONE};
            clk_sw_sync <= {clk_sw_sync[0], I_CLK_SWITCH};
            pin_sync1 <= I_PIN_ANALOG;
            pin_sync2 <= pin_sync1;
        end
    end
    // Data is assumed stable for several cycles around the done strobe
    assign conv_done = done_sync[1] & ~done_sync[2];

    // ==========================
    // Conversion sequencing
    // ==========================
    // RULE19 continuous with startup
    assign enabled = config_reg[ADCB_CFG_EN];
    assign conv_accept = conv_done & enabled & (startup_cnt == 13'h0000) & ~discard_next;
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_N)
        begin
            was_enabled <= 1'b0;
            startup_cnt <= 13'h0000;
            discard_next <= 1'b1;
        end
        else
        begin
            was_enabled <= enabled;
            if (enabled & ~was_enabled)
                startup_cnt <= 13'(ADCB_STARTUP_CYC);
            else if (startup_cnt != 13'h0000)
                startup_cnt <= startup_cnt - 13'h0001;
            // RULE20 drop first result
            if ((enabled & ~was_enabled) | wr_config | clk_sw_sync[1])
                discard_next <= 1'b1;
            else if (conv_done & enabled & (startup_cnt == 13'h0000))
                discard_next <= 1'b0;
        end
    end

    // ==========================
    // Correction and input select
    // ==========================
    adcb_correct u_correct
    (
        .i_raw(raw_sync2),
        .i_offset(offset_correction),
        .i_gain(gain_correction),
        .o_result(corrected),
        .o_sat(sat_now)
    );

    adcb_mux_decode u_pos
    (
        .i_code(config_reg[ADCB_CFG_MUXP_LO +: 4]),
        .o_sel(pos_sel)
    );

    adcb_mux_decode u_neg
    (
        .i_code(config_reg[ADCB_CFG_MUXN_LO +: 4]),
        .o_sel(neg_sel)
    );

    // ==========================
    // Transfer channel
    // ==========================
    // RULE22 config writes ignored here, except clearing enable in wrap mode returns the channel to idle
    assign store = conv_accept & (xstate == ADCB_XS_RUN);
    // RULE7 length in samples
    assign last_sample = (sample_index == buffer_length - 16'h0001);
    assign half_point = (sample_index == {1'b0, buffer_length[15:1]} - 16'h0001);
    assign next_index = last_sample ? 16'h0000 : sample_index + 16'h0001;
    assign next_pointer = buffer_start_address + {next_index[14:0], 1'b0};

    // RULE10 stop and full
    // RULE11 overrun after full
    // RULE13 half and full
    assign flag_set[ADCB_FL_SAT] = conv_accept & sat_now;
    assign flag_set[ADCB_FL_HALF] = store & half_point & (buffer_length > 16'h0001);
    assign flag_set[ADCB_FL_FULL] = store & last_sample;
    assign flag_set[ADCB_FL_OVR] = conv_accept & (xstate == ADCB_XS_DONE);

    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_N | xfer_reset)
        begin
            xstate <= ADCB_XS_IDLE;
            sample_index <= 16'h0000;
            current_write_pointer <= 16'h0000;
        end
        else if (xfer_load)
        begin
            xstate <= ADCB_XS_RUN;
            sample_index <= 16'h0000;
            current_write_pointer <= buffer_start_address;
        end
        else if (store)
        begin
            sample_index <= next_index;
            // RULE12 wrap to start
            current_write_pointer <= next_pointer;
            if (last_sample & ~wrap_mode_bit)
                xstate <= ADCB_XS_DONE;
        end
        else if (!enabled & wrap_mode_bit & (xstate == ADCB_XS_RUN))
            xstate <= ADCB_XS_IDLE;
    end

    // RULE23 write one clears
    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_N)
            converter_event_flags <= 4'h0;
        else
            converter_event_flags <= (converter_event_flags & ~(wr_flags ? wd[3:0] : 4'h0))
                | flag_set;
    end

    // ==========================
    // Registered outputs
    // ==========================
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RST_N)
        begin
            O_RAM_WRITE <= 1'b0;
            O_RAM_ADDRESS <= 16'h0000;
            O_RAM_WRITEDATA <= 16'h0000;
            O_POS_SEL <= 11'h400;
            O_NEG_SEL <= 11'h400;
            O_PERIOD <= 3'h0;
            O_MOD_ENABLE <= 1'b0;
            O_PIN_DIGITAL_OFF <= 6'h00;
        end
        else
        begin
            // RULE5 corrected word out
            // RULE14 pointer tracks writes
            O_RAM_WRITE <= store;
            O_RAM_ADDRESS <= current_write_pointer;
            O_RAM_WRITEDATA <= corrected;
            // RULE15 select outputs
            O_POS_SEL <= pos_sel;
            O_NEG_SEL <= neg_sel;
            // RULE21 period to modulator
            O_PERIOD <= config_reg[ADCB_CFG_PERIOD_LO +: 3];
            O_MOD_ENABLE <= enabled;
            // RULE17 analog pins off
            O_PIN_DIGITAL_OFF <= pin_sync2;
        end
    end
endmodule
`default_nettype wire

// file: test_adcb_top.sv
// Testbench: register access, source decode, correction and sample transfer
`timescale 1ns/10ps
`default_nettype none
module test_adcb_top
    import adcb_pkg::*;
();
    logic clk, rst_n, rd, wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [5:0] pins;
    logic clk_sw;
    wire logic [31:0] rdata;
    wire logic waitreq, mdone, ram_wr, mod_en;
    wire logic [15:0] mdata, ram_addr, ram_data;
    wire logic [10:0] pos_sel, neg_sel;
    wire logic [2:0] period;
    wire logic [5:0] dig_off;
    int fails = 0;
    int n_compared = 0;

    adcb_top dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_MOD_DATA(mdata), .I_MOD_DONE(mdone),
        .I_CLK_SWITCH(clk_sw), .I_PIN_ANALOG(pins), .O_POS_SEL(pos_sel), .O_NEG_SEL(neg_sel),
        .O_PERIOD(period), .O_MOD_ENABLE(mod_en), .O_PIN_DIGITAL_OFF(dig_off),
        .O_RAM_WRITE(ram_wr), .O_RAM_ADDRESS(ram_addr), .O_RAM_WRITEDATA(ram_data));
    adcb_partner u_part (.i_clk(clk), .o_mod_data(mdata), .o_mod_done(mdone),
        .i_ram_write(ram_wr), .i_ram_address(ram_addr), .i_ram_writedata(ram_data));

    // ==========================
    // Helpers
    // ==========================
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        d = rdata;
        rd <= 1'b0;
    endtask

    // Offset add, 1.15 gain, clamp to 16 bits signed
    function automatic logic [31:0] corr(input logic [15:0] raw, off, gain);
        logic signed [17:0] s;
        logic signed [35:0] p;
        s = $signed(raw) + $signed(off);
        p = (s * $signed({1'b0, gain})) >>> 15;
        if (p > 36'sh7FFF) p = 36'sh7FFF;
        if (p < -36'sh8000) p = -36'sh8000;
        return {16'h0, p[15:0]};
    endfunction

    function automatic logic [31:0] sel_of(input logic [3:0] c);
        if (c < 4'h6) return 32'h1 << c;
        if (c >= 4'h8 && c <= 4'hB) return 32'h1 << (c - 4'h2);
        return 32'h400;
    endfunction

    // ==========================
    // Scenarios
    // ==========================
    task automatic test_reset_regs();
        logic [31:0] d;
        bus_read(ADCB_OFFS_OFFSET, d);
        compare(d, 32'h0);
        bus_read(ADCB_OFFS_GAIN, d);
        compare(d, {16'h0, ADCB_RST_GAIN});
        bus_read(ADCB_OFFS_LAST, d);
        compare(d, 32'h0);
    endtask

    task automatic test_mux_codes();
        logic [3:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            bus_write(ADCB_OFFS_CONFIG, {20'h0, c, 4'hF - c, c[2:0], 1'b0});
            repeat (3) @(posedge clk);
            compare({21'h0, pos_sel}, sel_of(c));
            compare({21'h0, neg_sel}, sel_of(4'hF - c));
            compare({29'h0, period}, {29'h0, c[2:0]});
        end
        pins <= 6'h2D;
        repeat (5) @(posedge clk);
        compare({26'h0, dig_off}, 32'h2D);
    endtask

    task automatic test_linear();
        logic [31:0] d;
        logic [15:0] raws [4] = '{16'h1000, 16'hF000, 16'h6000, 16'h9000};
        bus_write(ADCB_OFFS_OFFSET, 32'h0100);
        bus_write(ADCB_OFFS_GAIN, 32'hC000);
        bus_read(ADCB_OFFS_GAIN, d);
        compare(d, 32'hC000);
        bus_write(ADCB_OFFS_BUF_START, 32'h0010);
        bus_write(ADCB_OFFS_BUF_LEN, 32'h4);
        bus_write(ADCB_OFFS_XFER_CTRL, 32'h1);
        bus_write(ADCB_OFFS_CONFIG, 32'h091);
        repeat (440) @(posedge clk);
        u_part.convert(16'h1234);
        u_part.convert(16'h1234);
        compare(u_part.n_writes, 32'h0);
        bus_write(ADCB_OFFS_XFER_CTRL, 32'h2);
        bus_read(ADCB_OFFS_CUR_PTR, d);
        compare(d, 32'h10);
        for (int i = 0; i < 4; i++)
        begin
            u_part.convert(raws[i]);
            if (i == 1)
            begin
                bus_read(ADCB_OFFS_FLAGS, d);
                compare(d, 32'h2);
            end
        end
        for (int i = 0; i < 4; i++)
            compare({16'h0, u_part.mem[8 + i]}, corr(raws[i], 16'h0100, 16'hC000));
        bus_read(ADCB_OFFS_FLAGS, d);
        compare(d, 32'h7);
        u_part.convert(16'h0000);
        compare(u_part.n_writes, 32'h4);
        bus_read(ADCB_OFFS_FLAGS, d);
        compare(d, 32'hF);
        bus_write(ADCB_OFFS_FLAGS, 32'h0);
        bus_read(ADCB_OFFS_FLAGS, d);
        compare(d, 32'hF);
        bus_write(ADCB_OFFS_FLAGS, 32'hF);
        bus_read(ADCB_OFFS_FLAGS, d);
        compare(d, 32'h0);
    endtask

    task automatic test_wrap();
        logic [31:0] d;
        logic [31:0] n0;
        bus_write(ADCB_OFFS_XFER_CTRL, 32'h1);
        bus_write(ADCB_OFFS_BUF_START, 32'h0040);
        bus_write(ADCB_OFFS_BUF_LEN, 32'h2);
        bus_write(ADCB_OFFS_XFER_CTRL, 32'h6);
        bus_write(ADCB_OFFS_CONFIG, 32'h191);
        n0 = u_part.n_writes;
        u_part.convert(16'h0100);
        u_part.convert(16'h0200);
        u_part.convert(16'h0300);
        u_part.convert(16'h0400);
        compare(u_part.n_writes, n0 + 32'h3);
        compare({16'h0, u_part.mem[32]}, corr(16'h0400, 16'h0100, 16'hC000));
        compare({16'h0, u_part.mem[33]}, corr(16'h0300, 16'h0100, 16'hC000));
        compare(u_part.last_addr, 32'h40);
        bus_read(ADCB_OFFS_FLAGS, d);
        compare(d, 32'h6);
        // Clock switch drops the next result, the one after lands at the second slot
        clk_sw <= 1'b1;
        repeat (3) @(posedge clk);
        clk_sw <= 1'b0;
        u_part.convert(16'h0500);
        u_part.convert(16'h0600);
        compare(u_part.n_writes, n0 + 32'h4);
        compare({16'h0, u_part.mem[33]}, corr(16'h0600, 16'h0100, 16'hC000));
    endtask

    // ==========================
    // Clock, reset, sequence, watchdog
    // ==========================
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        pins = 6'h00;
        clk_sw = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        test_reset_regs();
        test_mux_codes();
        test_linear();
        test_wrap();
        report_and_stop();
    end

    // Whole run needs under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
